// file: core/sdsm_pkg.sv
// Purpose : shared constants and types for the spool demand shaping monitor
// Assumes : one 100 MHz clock, word-aligned register port
// Notes   : byte addresses below are multiples of four
package sdsm_pkg;

   // ****************************************************************
   // widths and timing
   // ****************************************************************
   localparam int DW          = 16;        // demand and deviation width
   localparam int CLK_PERIOD_NS = 10;      // 100 MHz
   localparam int HOLD_UNIT_NS  = 1000000; // one millisecond
   localparam int MS_CYCLES_DEF = HOLD_UNIT_NS / CLK_PERIOD_NS;
   localparam int LUT_AW_DEF  = 6;         // curve table index bits
   localparam int NCH         = 2;         // watch channels
   localparam int CH_POS      = 0;         // spool position loop
   localparam int CH_PRS      = 1;         // pressure loop
   localparam int PIPE_LAT    = 4;         // shaping stages

   // ****************************************************************
   // register map (byte addresses)
   // ****************************************************************
   localparam logic [7:0] ADR_CTRL     = 8'h00;
   localparam logic [7:0] ADR_RATIO    = 8'h04; // den[31:16], num[15:0]
   localparam logic [7:0] ADR_WIDTH    = 8'h08;
   localparam logic [7:0] ADR_JUMP_POS = 8'h0c;
   localparam logic [7:0] ADR_JUMP_NEG = 8'h10;
   localparam logic [7:0] ADR_SHIFT    = 8'h14;
   localparam logic [7:0] ADR_MON_BASE = 8'h18; // high, low, hold per ch
   localparam logic [7:0] MON_STRIDE   = 8'h0c;
   localparam logic [7:0] MON_HIGH     = 8'h00;
   localparam logic [7:0] MON_LOW      = 8'h04;
   localparam logic [7:0] MON_HOLD     = 8'h08;
   localparam logic [7:0] ADR_STATUS   = 8'h30; // sticky, read clears
   localparam logic [7:0] ADR_MASK     = 8'h34;
   localparam logic [7:0] ADR_FLAGS    = 8'h38; // unit_state_flags
   localparam logic [7:0] ADR_LUT_IDX  = 8'h3c;
   localparam logic [7:0] ADR_LUT_DATA = 8'h40;

   // ctrl field positions
   localparam int CTRL_DIR_BIT   = 0;
   localparam int CTRL_CURVE_BIT = 1;
   localparam int CTRL_ZONE_LSB  = 2;
   localparam int CTRL_WATCH_LSB = 4; // one bit per channel
   localparam int RATIO_DEN_LSB  = 16;
   localparam int UNIT_ERR_BIT   = 0; // error bit of unit_state_flags

   // reset values
   localparam logic [15:0] RST_RATIO_NUM = 16'h0001;
   localparam logic [15:0] RST_RATIO_DEN = 16'h0001;
   localparam logic [15:0] RST_ZERO16    = 16'h0000;
   localparam logic [15:0] RST_HIGH      = 16'h7fff;
   localparam logic [15:0] RST_LOW       = 16'h8000;

   typedef enum logic [1:0] {
      SDSM_ZONE_OFF   = 2'h0,
      SDSM_ZONE_STEP  = 2'h1,
      SDSM_ZONE_SERVO = 2'h2
   } sdsm_zone_type;

   typedef struct packed {
      logic                  dir_scale_select;
      logic                  curve_select;
      sdsm_zone_type         zero_zone_select;
      logic [NCH-1:0]        deviation_watch_select;
   } sdsm_ctrl_type;

   typedef struct packed {
      logic                  valid;
      logic signed [DW-1:0]  value;
   } sdsm_sample_type;

endpackage

// file: core/sdsm_top.sv
// Purpose : spool demand shaping chain and control deviation watch
// Assumes : inputs synchronous to clk, reads answered one cycle later
// Notes   : four-stage pipeline, one result per input sample
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps

module sdsm_top #(
   parameter int MS_CYCLES = sdsm_pkg::MS_CYCLES_DEF, // cycles per ms
   parameter int LUT_AW    = sdsm_pkg::LUT_AW_DEF     // table index bits
) (
   input  wire logic                     clk,        // 100 MHz clock
   input  wire logic                     rst,        // async, high
   input  wire logic [7:0]               addr,       // byte address
   input  wire logic [31:0]              wdata,      // write data
   input  wire logic                     wr,         // write strobe
   input  wire logic                     rd,         // read strobe
   output logic [31:0]                   rdata,      // read data, +1 cycle
   input  wire sdsm_pkg::sdsm_sample_type demand_in, // spool demand in
   output sdsm_pkg::sdsm_sample_type     demand_out, // shaped demand
   input  wire logic [sdsm_pkg::NCH-1:0][sdsm_pkg::DW-1:0] deviation,
                                                     // per-loop deviation
   output logic [15:0]                   unit_state_flags, // status word
   output logic                          irq         // masked sticky level
);
   import sdsm_pkg::*;

   // ****************************************************************
   // configuration registers
   // ****************************************************************
   sdsm_ctrl_type        ctrl_r;
   logic [15:0]          ratio_num_r;
   logic [15:0]          ratio_den_r;
   logic [15:0]          zero_zone_width_r;
   logic [15:0]          positive_jump_height_r;
   logic [15:0]          negative_jump_height_r;
   logic [15:0]          demand_shift_r;
   logic [NCH-1:0]       status_r;
   logic [NCH-1:0]       mask_r;
   logic [LUT_AW-1:0]    lut_idx_r;
   logic [DW-1:0]        lut_r [0:(1<<LUT_AW)-1];
   logic [15:0]          high_r [NCH];
   logic [15:0]          low_r  [NCH];
   logic [15:0]          hold_r [NCH];
   logic [NCH-1:0]       mon_err;   // delay expired, per channel
   logic [31:0]          rdata_nxt;

   // control and shaping parameters
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ctrl_r                 <= '0;
         ratio_num_r            <= RST_RATIO_NUM;
         ratio_den_r            <= RST_RATIO_DEN;
         zero_zone_width_r      <= RST_ZERO16;
         positive_jump_height_r <= RST_ZERO16;
         negative_jump_height_r <= RST_ZERO16;
         demand_shift_r         <= RST_ZERO16;
         mask_r                 <= '0;
      end else if (wr) begin
         case (addr)
            ADR_CTRL: begin
               ctrl_r.dir_scale_select <= wdata[CTRL_DIR_BIT];
               ctrl_r.curve_select     <= wdata[CTRL_CURVE_BIT];
               ctrl_r.zero_zone_select <=
                  sdsm_zone_type'(wdata[CTRL_ZONE_LSB +: 2]);
               ctrl_r.deviation_watch_select <=
                  wdata[CTRL_WATCH_LSB +: NCH];
            end
            ADR_RATIO: begin
               ratio_num_r <= wdata[15:0];
               ratio_den_r <= wdata[RATIO_DEN_LSB +: 16];
            end
            ADR_WIDTH:    zero_zone_width_r      <= wdata[15:0];
            ADR_JUMP_POS: positive_jump_height_r <= wdata[15:0];
            ADR_JUMP_NEG: negative_jump_height_r <= wdata[15:0];
            ADR_SHIFT:    demand_shift_r         <= wdata[15:0];
            ADR_MASK:     mask_r                 <= wdata[NCH-1:0];
            default: ;
         endcase
      end
   end

   // curve table: index auto-advances so a block load is one write each
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         lut_idx_r <= '0;
      end else if (wr && addr == ADR_LUT_IDX) begin
         lut_idx_r <= wdata[LUT_AW-1:0];
      end else if (wr && addr == ADR_LUT_DATA) begin
         lut_idx_r <= lut_idx_r + 1'b1;
      end
   end

   // table storage has no reset; software loads it before enabling
   always_ff @(posedge clk) begin
      if (wr && addr == ADR_LUT_DATA) begin
         lut_r[lut_idx_r] <= wdata[DW-1:0];
      end
   end

   // ****************************************************************
   // shaping pipeline, spool demand only
   // ****************************************************************
   function automatic logic signed [DW-1:0] sat(
      input logic signed [33:0] v);
      logic signed [33:0] hi;
      logic signed [33:0] lo;
      hi = 34'sh0_0000_7fff;
      lo = -34'sh0_0000_8000;
      if (v > hi)      sat = 16'sh7fff;
      else if (v < lo) sat = 16'sh8000;
      else             sat = v[DW-1:0];
   endfunction

   sdsm_sample_type      s1_r, s2_r, s3_r;
   sdsm_sample_type      s1_nxt, s2_nxt, s3_nxt, s4_nxt;
   logic signed [33:0]   dir_prod;
   logic signed [33:0]   zone_mag;
   logic signed [33:0]   zone_width;
   logic signed [33:0]   jump;
   logic signed [33:0]   zone_val;
   logic [LUT_AW-1:0]    lut_idx;

   // stage 1: direction gain on the positive side only
   always_comb begin
      s1_nxt   = demand_in;
      dir_prod = 34'(demand_in.value) * $signed({18'h0, ratio_num_r});
      if (ctrl_r.dir_scale_select && demand_in.value > 0
          && ratio_den_r != '0) begin
         s1_nxt.value = sat(dir_prod / $signed({18'h0, ratio_den_r}));
      end
   end

   // stage 2: curve table, offset-binary index from the top bits
   always_comb begin
      s2_nxt  = s1_r;
      lut_idx = {~s1_r.value[DW-1], s1_r.value[DW-2 -: LUT_AW-1]};
      if (ctrl_r.curve_select) begin
         s2_nxt.value = lut_r[lut_idx];
      end
   end

   // stage 3: dead band; inside the zone step gives zero, servo ramps
   always_comb begin
      s3_nxt     = s2_r;
      zone_width = $signed({18'h0, zero_zone_width_r});
      zone_mag   = (s2_r.value < 0) ? -34'(s2_r.value) : 34'(s2_r.value);
      jump       = (s2_r.value < 0)
                 ? $signed({18'h0, negative_jump_height_r})
                 : $signed({18'h0, positive_jump_height_r});
      zone_val   = 34'(s2_r.value);
      case (ctrl_r.zero_zone_select)
         SDSM_ZONE_STEP, SDSM_ZONE_SERVO: begin
            if (zone_mag <= zone_width) begin
               if (ctrl_r.zero_zone_select == SDSM_ZONE_STEP
                   || zone_width == 0) begin
                  zone_val = '0;
               end else begin
                  zone_val = (34'(s2_r.value) * jump) / zone_width;
               end
            end else if (s2_r.value < 0) begin
               zone_val = 34'(s2_r.value) - jump;
            end else begin
               zone_val = 34'(s2_r.value) + jump;
            end
            s3_nxt.value = sat(zone_val);
         end
         default: ;
      endcase
   end

   // stage 4: zero correction shift, saturating
   always_comb begin
      s4_nxt       = s3_r;
      s4_nxt.value = sat(34'(s3_r.value)
                         + 34'($signed(demand_shift_r)));
   end

   // pipeline registers; one stage per concern keeps timing short
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         s1_r       <= '0;
         s2_r       <= '0;
         s3_r       <= '0;
         demand_out <= '0;
      end else begin
         s1_r       <= s1_nxt;
         s2_r       <= s2_nxt;
         s3_r       <= s3_nxt;
         demand_out <= s4_nxt;
      end
   end

   // ****************************************************************
   // deviation watch, one per loop
   // ****************************************************************
   logic [31:0] ms_cnt_r;
   logic        ms_tick_r;

   // shared millisecond tick
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         ms_cnt_r  <= '0;
         ms_tick_r <= 1'b0;
      end else if (ms_cnt_r == 32'(MS_CYCLES - 1)) begin
         ms_cnt_r  <= '0;
         ms_tick_r <= 1'b1;
      end else begin
         ms_cnt_r  <= ms_cnt_r + 32'h1;
         ms_tick_r <= 1'b0;
      end
   end

   logic [16:0] hold_cnt_r [NCH];
   logic [NCH-1:0] viol;

   for (genvar c = 0; c < NCH; c++) begin : g_mon
      localparam logic [7:0] BASE = ADR_MON_BASE + 8'(c) * MON_STRIDE;

      // limits and delay of this loop
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            high_r[c] <= RST_HIGH;
            low_r[c]  <= RST_LOW;
            hold_r[c] <= RST_ZERO16;
         end else if (wr) begin
            if (addr == BASE + MON_HIGH) high_r[c] <= wdata[15:0];
            if (addr == BASE + MON_LOW)  low_r[c]  <= wdata[15:0];
            if (addr == BASE + MON_HOLD) hold_r[c] <= wdata[15:0];
         end
      end

      assign viol[c] = ctrl_r.deviation_watch_select[c]
         && ($signed(deviation[c]) > $signed(high_r[c])
          || $signed(deviation[c]) < $signed(low_r[c]));

      // elapsed ms of the current violation; error once past the delay
      always_ff @(posedge clk or posedge rst) begin
         if (rst) begin
            hold_cnt_r[c] <= '0;
         end else if (!viol[c]) begin
            hold_cnt_r[c] <= '0;
         end else if (ms_tick_r && !hold_cnt_r[c][16]) begin
            hold_cnt_r[c] <= hold_cnt_r[c] + 17'h1;
         end
      end

      assign mon_err[c] = viol[c]
         && (hold_cnt_r[c] > {1'b0, hold_r[c]});
   end

   // ****************************************************************
   // status, interrupt and unit flags
   // ****************************************************************
   logic status_clr;
   assign status_clr = rd && addr == ADR_STATUS;

   // sticky bits: a new error in the clearing cycle survives
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         status_r <= '0;
      end else begin
         status_r <= (status_r & ~{NCH{status_clr}}) | mon_err;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irq <= 1'b0;
      end else begin
         irq <= |(status_r & mask_r);
      end
   end

   // error bit follows the live error of either loop
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         unit_state_flags <= '0;
      end else begin
         unit_state_flags <= 16'(|mon_err) << UNIT_ERR_BIT;
      end
   end

   // ****************************************************************
   // read port
   // ****************************************************************
   always_comb begin
      rdata_nxt = '0;
      case (addr)
         ADR_CTRL: begin
            rdata_nxt[CTRL_DIR_BIT]   = ctrl_r.dir_scale_select;
            rdata_nxt[CTRL_CURVE_BIT] = ctrl_r.curve_select;
            rdata_nxt[CTRL_ZONE_LSB +: 2] = ctrl_r.zero_zone_select;
            rdata_nxt[CTRL_WATCH_LSB +: NCH] =
               ctrl_r.deviation_watch_select;
         end
         ADR_RATIO:    rdata_nxt = {ratio_den_r, ratio_num_r};
         ADR_WIDTH:    rdata_nxt[15:0] = zero_zone_width_r;
         ADR_JUMP_POS: rdata_nxt[15:0] = positive_jump_height_r;
         ADR_JUMP_NEG: rdata_nxt[15:0] = negative_jump_height_r;
         ADR_SHIFT:    rdata_nxt[15:0] = demand_shift_r;
         ADR_MON_BASE + MON_HIGH: rdata_nxt[15:0] = high_r[CH_POS];
         ADR_MON_BASE + MON_LOW:  rdata_nxt[15:0] = low_r[CH_POS];
         ADR_MON_BASE + MON_HOLD: rdata_nxt[15:0] = hold_r[CH_POS];
         ADR_MON_BASE + MON_STRIDE + MON_HIGH:
            rdata_nxt[15:0] = high_r[CH_PRS];
         ADR_MON_BASE + MON_STRIDE + MON_LOW:
            rdata_nxt[15:0] = low_r[CH_PRS];
         ADR_MON_BASE + MON_STRIDE + MON_HOLD:
            rdata_nxt[15:0] = hold_r[CH_PRS];
         ADR_STATUS:   rdata_nxt[NCH-1:0] = status_r;
         ADR_MASK:     rdata_nxt[NCH-1:0] = mask_r;
         ADR_FLAGS:    rdata_nxt[15:0] = unit_state_flags;
         ADR_LUT_IDX:  rdata_nxt[LUT_AW-1:0] = lut_idx_r;
         ADR_LUT_DATA: rdata_nxt[DW-1:0] = lut_r[lut_idx_r];
         default: ;
      endcase
   end

   // data stand only in the cycle after the read, zero otherwise
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         rdata <= '0;
      end else begin
         rdata <= rd ? rdata_nxt : 32'h0;
      end
   end

   // ****************************************************************
   // assertions
   // ****************************************************************
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   a_pipe_latency: assert property (
      demand_in.valid |-> ##4 demand_out.valid)
      else $error("shaped sample did not leave after four cycles");

   a_dir_off_pass: assert property (
      !ctrl_r.dir_scale_select && !$past(ctrl_r.dir_scale_select)
      |-> s1_r.value == $past(demand_in.value))
      else $error("direction stage changed value while off");

   a_dir_neg_pass: assert property (
      $past(demand_in.value) <= 0 |-> s1_r.value == $past(demand_in.value))
      else $error("direction factor touched non-positive input");

   a_step_zero: assert property (
      ctrl_r.zero_zone_select == SDSM_ZONE_STEP && zone_mag <= zone_width
      && $stable(ctrl_r.zero_zone_select) ##1 $stable(ctrl_r)
      |-> s3_r.value == 16'sh0000)
      else $error("step zone did not output zero");

   a_shift_add: assert property (
      demand_shift_r == 16'h0 && $stable(demand_shift_r)
      |-> ##1 demand_out.value == $past(s3_r.value))
      else $error("zero shift altered the demand");

   a_watch_off: assert property (
      !ctrl_r.deviation_watch_select[CH_POS] |-> !mon_err[CH_POS]
      ##1 !status_r[CH_POS] || $past(status_r[CH_POS]))
      else $error("disabled watch raised an error");

   a_err_restart: assert property (
      !viol[CH_PRS] |=> hold_cnt_r[CH_PRS] == 17'h0)
      else $error("delay count not restarted");

   a_err_sticky: assert property (
      mon_err[CH_POS] |=> status_r[CH_POS] && unit_state_flags[UNIT_ERR_BIT])
      else $error("error did not reach status and flags");

   a_irq_level: assert property (##1 irq ==
      $past(|(status_r & mask_r)))
      else $error("interrupt does not follow masked status");

   c_table_mode: cover property (ctrl_r.curve_select
      && demand_in.valid ##4 demand_out.valid);
   c_servo_zone: cover property (ctrl_r.zero_zone_select == SDSM_ZONE_SERVO
      && zone_mag < zone_width && zone_mag > 0);
   c_prs_error: cover property (mon_err[CH_PRS] ##1 irq);
endmodule // sdsm_top

// file: dv/sdsm_master_model.sv
// Purpose : network master model that sets up the valve parameters
// Assumes : one-cycle strobes, read data stand one cycle after the strobe
// Notes   : the bench calls the tasks, nothing is driven between them
`timescale 1ns/10ps
module sdsm_master_model (
   input  wire logic        clk,   // bench clock
   output logic [7:0]       addr,  // byte address
   output logic [31:0]      wdata, // write data
   output logic             wr,    // write strobe
   output logic             rd,    // read strobe
   input  wire logic [31:0] rdata  // read data
);
   // idle bus at time zero
   initial begin
      addr  = 8'h00;
      wdata = 32'h0;
      wr    = 1'b0;
      rd    = 1'b0;
   end
   // write is taken at the edge after the strobe rises
   task automatic put(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      wdata <= d;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask
   // data are only valid in the single cycle after the taking edge
   task automatic get(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1;
      d = rdata;
   endtask
endmodule // sdsm_master_model

// file: dv/tb_sdsm_top.sv
// Purpose : self-checking bench for the demand shaping chain and watch
// Assumes : short millisecond tick so the watch settles in a few cycles
// Notes   : expected samples come from a bench model of the chain
`timescale 1ns/10ps
module tb_sdsm_top;
   import sdsm_pkg::*;
   localparam int MSC = 4; // cycles per tick, shortened
   logic clk, rst, wr, rd, irq;
   logic [7:0]             addr;
   logic [31:0]            wdata, rdata, rv;
   logic [15:0]            unit_state_flags;
   logic [15:0]            lut [64];
   sdsm_sample_type        demand_in, demand_out;
   logic [NCH-1:0][DW-1:0] deviation;
   int fails, check_count, cyc, num, den, wid, jp, jn, sh, zone;
   bit dir, crv;
   int exp_q[$];

   sdsm_master_model m (.clk(clk), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata));
   sdsm_top #(.MS_CYCLES(MSC)) sdsm_top_inst (.clk(clk), .rst(rst),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .demand_in(demand_in), .demand_out(demand_out),
      .deviation(deviation), .unit_state_flags(unit_state_flags),
      .irq(irq));

   // ****************************************************************
   // helpers
   // ****************************************************************
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // a hang counts as a mismatch
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fails++;
         wrap_up();
      end
   end
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   function automatic int sat(input int x);
      return x > 32767 ? 32767 : (x < -32768 ? -32768 : x);
   endfunction
   // chain order: direction, curve, dead band, shift
   function automatic int model(input int v);
      int x, j;
      x = v;
      if (dir && x > 0 && den != 0) x = sat(x * num / den);
      if (crv) x = int'(signed'(lut[((x + 32768) >> 10) & 63]));
      j = x < 0 ? jn : jp;
      if (zone != 0 && (x < 0 ? -x : x) <= wid)
         x = (zone == 2 && wid != 0) ? x * j / wid : 0;
      else if (zone != 0) x = sat(x < 0 ? x - j : x + j);
      return sat(x + sh);
   endfunction
   task automatic cfg();
      m.put(ADR_CTRL, 32'(dir) | 32'(crv) << 1 | 32'(zone) << 2);
      m.put(ADR_RATIO, {den[15:0], num[15:0]});
      m.put(ADR_WIDTH, 32'(wid));
      m.put(ADR_JUMP_POS, 32'(jp));
      m.put(ADR_JUMP_NEG, 32'(jn));
      m.put(ADR_SHIFT, {16'h0, sh[15:0]});
   endtask
   // back-to-back samples: full-scale ends, zone edges and zero first, then random
   task automatic batch(input int n);
      int v;
      for (int i = 0; i < n; i++) begin
         case (i)
            0: v = 32767;
            1: v = -32768;
            2: v = wid;
            3: v = -wid - 1;
            4: v = 0;
            default: v = int'(signed'(16'($urandom)));
         endcase
         @(posedge clk);
         demand_in <= '{1'b1, 16'(v)};
         exp_q.push_back(model(v));
      end
      @(posedge clk);
      demand_in.valid <= 1'b0;
      repeat (PIPE_LAT + 2) @(posedge clk);
      chk(exp_q.size(), 0);
   endtask
   // a sample nobody sent is a mismatch, not a silent zero
   always @(negedge clk) begin
      if (!rst && demand_out.valid === 1'b1) begin
         if (exp_q.size() == 0) chk(32'h1, 32'h0);
         else chk(32'(demand_out.value), exp_q.pop_front());
      end
   end

   // ****************************************************************
   // main sequence
   // ****************************************************************
   initial begin
      rst = 1'b1;
      demand_in = '0;
      deviation = '0;
      {fails, check_count, cyc, zone, wid, jp, jn, sh} = '0;
      {dir, crv, num, den} = {2'b00, 32'd1, 32'd1};
      void'($urandom(32'hd9fef165));
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      m.get(ADR_RATIO, rv);
      chk(rv, 32'h00010001);
      m.get(ADR_MON_BASE + MON_HIGH, rv);
      chk(rv, 32'h00007fff);
      m.get(ADR_MON_BASE + MON_LOW, rv);
      chk(rv, 32'h00008000);
      m.get(8'hfc, rv);
      chk(rv, 32'h0);
      batch(20);
      m.put(ADR_LUT_IDX, 32'h0);
      for (int i = 0; i < 64; i++) begin
         lut[i] = 16'(i * 900 - 28000);
         m.put(ADR_LUT_DATA, {16'h0, lut[i]});
      end
      for (int k = 0; k < 6; k++) begin
         dir = k inside {0, 1, 5};
         crv = k inside {4, 5};
         zone = k == 2 ? 1 : (k inside {3, 5} ? 2 : 0);
         num = k == 1 ? 5 : 2;
         den = k == 1 ? 2 : 3;
         {wid, jp, jn} = {200 + k, 300, 100};
         sh = k == 5 ? -700 : 0;
         cfg();
         batch(40);
      end
      // deviation watch, spool position loop, high limit
      m.put(ADR_MON_BASE + MON_HOLD, 32'h2);
      m.put(ADR_MON_BASE + MON_HIGH, 32'h64);
      m.put(ADR_MASK, 32'h1);
      m.put(ADR_CTRL, 32'h0);
      @(posedge clk) deviation[0] <= 16'h0065;
      tick(30);
      chk(unit_state_flags, 16'h0);
      m.put(ADR_CTRL, 32'h10);
      repeat (5) begin
         repeat (6) @(posedge clk);
         deviation[0] <= 16'h0064;
         repeat (2) @(posedge clk);
         deviation[0] <= 16'h0065;
      end
      tick(8);
      chk(unit_state_flags, 16'h0);
      for (int i = 0; i < 40 && unit_state_flags[0] !== 1'b1; i++) tick(1);
      chk(unit_state_flags, 16'h1);
      tick(2);
      chk(irq, 1'b1);
      @(posedge clk) deviation[0] <= 16'h0;
      tick(3);
      chk(unit_state_flags, 16'h0);
      m.get(ADR_STATUS, rv);
      chk(rv, 32'h1);
      tick(2);
      chk(irq, 1'b0);
      // pressure loop, low limit, its bit is masked off
      m.put(ADR_MON_BASE + MON_STRIDE + MON_LOW, 32'h0000ff00);
      m.put(ADR_CTRL, 32'h20);
      @(posedge clk) deviation[1] <= 16'hfeff;
      for (int i = 0; i < 40 && unit_state_flags[0] !== 1'b1; i++) tick(1);
      chk(unit_state_flags, 16'h1);
      tick(2);
      chk(irq, 1'b0);
      m.get(ADR_STATUS, rv);
      chk(rv, 32'h2);
      wrap_up();
   end
endmodule // tb_sdsm_top
